// ### include/snf_consts.svh
// constants for the sensor and node id frame builder
`ifndef SNF_CONSTS_SVH
`define SNF_CONSTS_SVH
`define SNF_START_DELIM    8'h7E
`define SNF_TYPE_SENSOR    8'h94
`define SNF_TYPE_NODE_ID   8'h95
`define SNF_OPT_ACKED      8'h01
`define SNF_OPT_BCAST      8'h02
`define SNF_OPT_APS_ENC    8'h20
`define SNF_SENS_ANALOG    8'h01
`define SNF_SENS_TEMP      8'h02
`define SNF_SENS_WATER     8'h60
`define SNF_NO_SENSOR      16'hFFFF
`define SNF_ADDR_UNKNOWN   16'hFFFE
`define SNF_STR_TERM       8'h00
`define SNF_SENSOR_LEN     16'h0017
`define SNF_NODE_FIXED_LEN 16'h001D
`define SNF_NODE_STR_OFS   6'h16
`define SNF_HDR_LAST       2'h2
`endif

// ### include/snf_pkg.sv
// types for the sensor and node id frame builder
package snf_pkg;
    typedef enum logic [2:0] {
        SNF_IDLE = 3'b000,
        SNF_HDR  = 3'b001,
        SNF_BODY = 3'b011,
        SNF_STR  = 3'b010,
        SNF_TAIL = 3'b110,
        SNF_SUM  = 3'b111
    } snf_state_e;
    typedef enum logic [1:0] {
        SNF_ROLE_COORD  = 2'h0,
        SNF_ROLE_ROUTER = 2'h1,
        SNF_ROLE_END    = 2'h2
    } snf_role_e;
    typedef enum logic [1:0] {
        SNF_EV_BUTTON = 2'h1,
        SNF_EV_JOIN   = 2'h2,
        SNF_EV_POWER  = 2'h3
    } snf_event_e;
endpackage : snf_pkg

// ### hdl/snf_sync2.sv
// two-flop synchroniser for the water detect pin
`timescale 1ns/1ns
module snf_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // level
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : snf_sync2

// ### hdl/snf_frame_builder.sv
// sensor read and node identification frame builder
// Behaviour
// - sensor sample gives frame type 0x94
// - sender 64-bit address at bytes 4-11
// - sender 16-bit address at bytes 12-13
// - sensor byte 14 holds receive options
// - sensor byte 15 flags present sensor data
// - four analog words, all-ones when absent
// - thermometer word, 0xFFFF when absent
// - node identification gives frame type 0x95
// - node byte 14 holds receive options
// - remote network address, 0xFFFE if unknown
// - remote 64-bit address at bytes 17-24
// - identifier string copied, zero terminated
// - parent address, 0xFFFE when no parent
// - byte 28 plus string length encodes remote device role
// - byte 29 plus string length encodes triggering event
// - bytes 30-31 plus string length hold profile identifier
`timescale 1ns/1ns
`include "snf_consts.svh"
module snf_frame_builder import snf_pkg::*; #(
    parameter int             MAX_STR    = 20,
    parameter logic [15:0]    PROFILE_ID = 16'hABCD  // arbitrary value
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // configuration
    input  wire logic [7:0]   api_output_option,
    // sensor sample request
    input  wire logic         sens_req,
    input  wire logic [63:0]  sens_src_addr64,
    input  wire logic [15:0]  sens_src_addr16,
    input  wire logic         sens_acked,
    input  wire logic         sens_bcast,
    input  wire logic         sens_aps_enc,
    input  wire logic         sens_analog_found,
    input  wire logic         sens_temp_found,
    input  wire logic [63:0]  sens_analog,
    input  wire logic [15:0]  sens_temp,
    input  wire logic         water_detect_pin,
    // node identification request
    input  wire logic         node_req,
    input  wire logic [63:0]  node_src_addr64,
    input  wire logic [15:0]  node_src_addr16,
    input  wire logic         node_acked,
    input  wire logic         node_bcast,
    input  wire logic         node_remote16_known,
    input  wire logic [15:0]  node_remote16,
    input  wire logic [63:0]  node_remote64,
    input  wire logic [MAX_STR*8-1:0] node_identifier_string,
    input  wire logic [4:0]   node_str_len,
    input  wire logic         node_has_parent,
    input  wire logic [15:0]  node_parent16,
    input  wire logic [1:0]   node_role,
    input  wire logic [1:0]   node_event,
    // request status
    output logic              busy,
    output logic              req_taken,
    // serial byte stream
    output logic              tx_valid,
    output logic [7:0]        tx_data,
    input  wire logic         tx_ready
);
    // the string length port is five bits wide
    if (MAX_STR < 1 || MAX_STR > 31) begin : g_bad_max_str
        $error("MAX_STR must be 1 to 31");
    end

    typedef struct packed {
        snf_state_e  st;
        logic        is_node;
        logic [5:0]  idx;
        logic [7:0]  sum;
        logic        valid;
        logic [7:0]  data;
        logic        taken;
        logic        busy;
        logic [4:0]  slen;
        logic [255:0] body;
        logic [MAX_STR*8-1:0] str;
    } snf_state_s;

    snf_state_s cur_ff, nxt_cur;
    logic       water_sync;

    snf_sync2 u_water (
        .clk   (clk),
        .reset (reset),
        .din   (water_detect_pin),
        .dout  (water_sync)
    );

    logic [7:0]  s_opt, s_flags, n_opt, frame_type;
    logic [15:0] frame_len;
    logic        can_send;

    always_comb begin
        s_opt = 8'h00;
        if (sens_acked)   s_opt = s_opt | `SNF_OPT_ACKED;
        if (sens_bcast)   s_opt = s_opt | `SNF_OPT_BCAST;
        if (sens_aps_enc) s_opt = s_opt | `SNF_OPT_APS_ENC;
        s_flags = 8'h00;
        if (sens_analog_found) s_flags = s_flags | `SNF_SENS_ANALOG;
        if (sens_temp_found)   s_flags = s_flags | `SNF_SENS_TEMP;
        // water present means the synchronised pin reads low
        if (!water_sync)       s_flags = s_flags | `SNF_SENS_WATER;
        n_opt = 8'h00;
        if (node_acked) n_opt = n_opt | `SNF_OPT_ACKED;
        if (node_bcast) n_opt = n_opt | `SNF_OPT_BCAST;
    end

    assign can_send  = (api_output_option == 8'h00);
    assign frame_type = cur_ff.is_node ? `SNF_TYPE_NODE_ID
                                       : `SNF_TYPE_SENSOR;
    // node frame length grows with the identifier string
    assign frame_len = cur_ff.is_node
        ? `SNF_NODE_FIXED_LEN + {11'h000, cur_ff.slen}
        : `SNF_SENSOR_LEN;

    always_comb begin
        logic [7:0] b;
        b = 8'h00;
        nxt_cur       = cur_ff;
        nxt_cur.taken = 1'b0;
        // a byte stands until the host side accepts it
        if (cur_ff.valid && tx_ready) nxt_cur.valid = 1'b0;
        case (cur_ff.st)
            SNF_IDLE: begin
                // node requests win when both arrive together
                // a pending checksum byte leaves before a new frame
                if (can_send && !cur_ff.valid && node_req) begin
                    nxt_cur.is_node = 1'b1;
                    nxt_cur.slen = (node_str_len > 5'(MAX_STR))
                                 ? 5'(MAX_STR) : node_str_len;
                    nxt_cur.str  = node_identifier_string;
                    nxt_cur.body = {node_src_addr64, node_src_addr16,
                        n_opt,
                        node_remote16_known ? node_remote16
                                            : `SNF_ADDR_UNKNOWN,
                        node_remote64,
                        88'h0};
                    nxt_cur.st    = SNF_HDR;
                    nxt_cur.idx   = 6'h00;
                    nxt_cur.taken = 1'b1;
                end else if (can_send && !cur_ff.valid
                             && sens_req) begin
                    nxt_cur.is_node = 1'b0;
                    nxt_cur.slen = 5'h00;
                    nxt_cur.body = {sens_src_addr64,
                        sens_src_addr16,
                        s_opt, s_flags,
                        sens_analog_found ? sens_analog
                                          : {4{`SNF_NO_SENSOR}},
                        sens_temp_found ? sens_temp
                                        : `SNF_NO_SENSOR,
                        80'h0};
                    nxt_cur.st    = SNF_HDR;
                    nxt_cur.idx   = 6'h00;
                    nxt_cur.taken = 1'b1;
                end
            end
            default: begin
                if (!cur_ff.valid || tx_ready) begin
                    nxt_cur.valid = 1'b1;
                    nxt_cur.idx   = cur_ff.idx + 6'h01;
                    case (cur_ff.st)
                        SNF_HDR: begin
                            case (cur_ff.idx[1:0])
                                2'h0: b = `SNF_START_DELIM;
                                2'h1: b = frame_len[15:8];
                                2'h2: b = frame_len[7:0];
                                default: b = frame_type;
                            endcase
                            if (cur_ff.idx[1:0] == 2'h3) begin
                                nxt_cur.st  = SNF_BODY;
                                nxt_cur.idx = 6'h00;
                                nxt_cur.sum = frame_type;
                            end
                        end
                        SNF_BODY: begin
                            // shift out fields most significant first
                            b = cur_ff.body[255:248];
                            nxt_cur.body = {cur_ff.body[247:0], 8'h00};
                            nxt_cur.sum  = cur_ff.sum + b;
                            if (cur_ff.is_node && cur_ff.idx == 6'd20) begin
                                nxt_cur.st  = SNF_STR;
                                nxt_cur.idx = 6'h00;
                            end else if (!cur_ff.is_node
                                         && cur_ff.idx == 6'd21) begin
                                nxt_cur.st = SNF_SUM;
                            end
                        end
                        SNF_STR: begin
                            if (cur_ff.idx[4:0] == cur_ff.slen) begin
                                b = `SNF_STR_TERM;
                                nxt_cur.st  = SNF_TAIL;
                                nxt_cur.idx = 6'h00;
                                nxt_cur.body = {
                                    node_has_parent ? node_parent16
                                        : `SNF_ADDR_UNKNOWN,
                                    6'h00, node_role,
                                    6'h00, node_event,
                                    PROFILE_ID,
                                    208'h0};
                            end else begin
                                b = cur_ff.str[MAX_STR*8-1 -: 8];
                                nxt_cur.str = cur_ff.str << 8;
                            end
                            nxt_cur.sum = cur_ff.sum + b;
                        end
                        SNF_TAIL: begin
                            b = cur_ff.body[255:248];
                            nxt_cur.body = {cur_ff.body[247:0], 8'h00};
                            nxt_cur.sum  = cur_ff.sum + b;
                            if (cur_ff.idx == 6'd5) nxt_cur.st = SNF_SUM;
                        end
                        SNF_SUM: begin
                            b = 8'hFF - cur_ff.sum;
                            nxt_cur.st = SNF_IDLE;
                        end
                        default: nxt_cur.st = SNF_IDLE;
                    endcase
                    nxt_cur.data = b;
                end
            end
        endcase
        // busy leaves a flip-flop like the other outputs
        nxt_cur.busy = (nxt_cur.st != SNF_IDLE) || nxt_cur.valid;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign tx_valid  = cur_ff.valid;
    assign tx_data   = cur_ff.data;
    assign req_taken = cur_ff.taken;
    assign busy      = cur_ff.busy;

    logic [7:0] mon_cnt_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) mon_cnt_ff <= 8'h00;
        else if (cur_ff.taken) mon_cnt_ff <= 8'h00;
        else if (tx_valid && tx_ready) mon_cnt_ff <= mon_cnt_ff + 8'h01;
    end

    sequence s_taken;
        req_taken;
    endsequence

    // byte offsets inside the node frame move with the string length
    logic       hs;
    logic [7:0] str_end;
    assign hs      = tx_valid && tx_ready;
    assign str_end = 8'd25 + {3'h0, cur_ff.slen};

    a_no_send_off: assert property (
        @(posedge clk) disable iff (reset)
        (cur_ff.st == SNF_IDLE && api_output_option != 8'h00)
        |=> !req_taken)
        else $error("frame started with output option nonzero");
    a_delim_first: assert property (
        @(posedge clk) disable iff (reset)
        s_taken |=> tx_valid && tx_data == `SNF_START_DELIM)
        else $error("frame does not open with delimiter");
    a_sensor_type: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd3 && !cur_ff.is_node)
        |-> tx_data == `SNF_TYPE_SENSOR)
        else $error("wrong sensor frame type");
    a_node_type: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd3 && cur_ff.is_node)
        |-> tx_data == `SNF_TYPE_NODE_ID)
        else $error("wrong node frame type");
    a_sensor_len: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd2 && !cur_ff.is_node)
        |-> tx_data == 8'h17)
        else $error("wrong sensor frame length");
    a_node_len: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd2 && cur_ff.is_node)
        |-> tx_data == 8'h1D + {3'h0, cur_ff.slen})
        else $error("wrong node frame length");
    a_data_holds: assert property (
        @(posedge clk) disable iff (reset)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
        else $error("byte dropped under back-pressure");
    a_water_flag: assert property (
        @(posedge clk) disable iff (reset)
        (cur_ff.st == SNF_IDLE && can_send && !cur_ff.valid && sens_req
         && !node_req)
        |=> cur_ff.body[166:165] == {2{!$past(water_sync)}})
        else $error("water flag does not follow the pin");
    a_idle_after_sum: assert property (
        @(posedge clk) disable iff (reset)
        (cur_ff.st == SNF_SUM && (!cur_ff.valid || tx_ready))
        |=> cur_ff.st == SNF_IDLE && tx_valid)
        else $error("no return to idle after checksum");
    a_sensor_opts: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd14 && !cur_ff.is_node)
        |-> (tx_data & 8'hDC) == 8'h00)
        else $error("undefined sensor receive option bit");
    a_node_opts: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd14 && cur_ff.is_node)
        |-> tx_data[7:2] == 6'h00)
        else $error("undefined node receive option bit");
    a_sensor_flags: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd15 && !cur_ff.is_node)
        |-> (tx_data & 8'h9C) == 8'h00)
        else $error("undefined sensor flag bit");
    a_node_src_msb: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd4 && cur_ff.is_node)
        |-> tx_data == node_src_addr64[63:56])
        else $error("sender address not most significant first");
    a_node_net_msb: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd12 && cur_ff.is_node)
        |-> tx_data == node_src_addr16[15:8])
        else $error("sender network address misplaced");
    a_remote_unknown: assert property (
        @(posedge clk) disable iff (reset)
        (hs && mon_cnt_ff == 8'd15 && cur_ff.is_node && !node_remote16_known)
        |-> tx_data == 8'hFF)
        else $error("unknown remote address not marked");
    a_str_term: assert property (
        @(posedge clk) disable iff (reset)
        (hs && cur_ff.is_node && mon_cnt_ff == str_end)
        |-> tx_data == `SNF_STR_TERM)
        else $error("identifier string not terminated");
    a_role_code: assert property (
        @(posedge clk) disable iff (reset)
        (hs && cur_ff.is_node && mon_cnt_ff == str_end + 8'd3)
        |-> tx_data == {6'h00, node_role})
        else $error("device role byte wrong");
    a_event_code: assert property (
        @(posedge clk) disable iff (reset)
        (hs && cur_ff.is_node && mon_cnt_ff == str_end + 8'd4)
        |-> tx_data == {6'h00, node_event})
        else $error("source event byte wrong");
    a_profile_hi: assert property (
        @(posedge clk) disable iff (reset)
        (hs && cur_ff.is_node && mon_cnt_ff == str_end + 8'd5)
        |-> tx_data == PROFILE_ID[15:8])
        else $error("profile identifier high byte wrong");
    a_profile_lo: assert property (
        @(posedge clk) disable iff (reset)
        (hs && cur_ff.is_node && mon_cnt_ff == str_end + 8'd6)
        |-> tx_data == PROFILE_ID[7:0])
        else $error("profile identifier low byte wrong");
endmodule : snf_frame_builder

// ### verification/snf_host_model.sv
// host model that accepts and stores the outbound frame byte stream
`timescale 1ns/1ns
module snf_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // pacing control from the bench
    input  wire logic       stall,
    // byte stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] rx_q[$];
    logic       tick_ff;
    // host side conversion of the thermometer word to degrees
    function automatic real temp_c(input logic [15:0] t);
        if (t < 16'h0800) return real'(t) / 16.0;
        return -real'(t & 16'h07FF) / 16.0;
    endfunction : temp_c
    always_ff @(posedge clk or posedge reset) begin
        if (reset) tick_ff <= 1'b0;
        else tick_ff <= ~tick_ff;
    end
    // a slow host is ready only every other cycle
    assign tx_ready = ~stall | tick_ff;
    always @(posedge clk) begin
        if (!reset && tx_valid === 1'b1 && tx_ready) rx_q.push_back(tx_data);
    end
endmodule : snf_host_model

// ### verification/testbench.sv
// self-checking bench for the frame builder
`timescale 1ns/1ns
module testbench;
    import snf_pkg::*;
    localparam logic [15:0] PROF = 16'h5A3C; // arbitrary value
    logic         clk = 1'b0;
    logic         reset, stall, sens_req, node_req;
    logic [7:0]   api_output_option, tx_data;
    logic         sens_acked, sens_bcast, sens_aps_enc, water_detect_pin;
    logic         sens_analog_found, sens_temp_found;
    logic [63:0]  sens_src_addr64, sens_analog, node_src_addr64;
    logic [63:0]  node_remote64;
    logic [15:0]  sens_src_addr16, sens_temp, node_src_addr16;
    logic [15:0]  node_remote16, node_parent16;
    logic         node_acked, node_bcast, node_remote16_known;
    logic         node_has_parent;
    logic [159:0] node_identifier_string;
    logic [4:0]   node_str_len;
    logic [1:0]   node_role, node_event;
    logic         busy, req_taken, tx_valid, tx_ready;
    int           errors = 0;
    int           checked = 0;
    logic [7:0]   exp_q[$];

    snf_frame_builder #(.MAX_STR(20), .PROFILE_ID(PROF)) i_dut (
        .clk(clk), .reset(reset), .api_output_option(api_output_option),
        .sens_req(sens_req), .sens_src_addr64(sens_src_addr64),
        .sens_src_addr16(sens_src_addr16), .sens_acked(sens_acked),
        .sens_bcast(sens_bcast), .sens_aps_enc(sens_aps_enc),
        .sens_analog_found(sens_analog_found),
        .sens_temp_found(sens_temp_found), .sens_analog(sens_analog),
        .sens_temp(sens_temp), .water_detect_pin(water_detect_pin),
        .node_req(node_req), .node_src_addr64(node_src_addr64),
        .node_src_addr16(node_src_addr16), .node_acked(node_acked),
        .node_bcast(node_bcast),
        .node_remote16_known(node_remote16_known),
        .node_remote16(node_remote16), .node_remote64(node_remote64),
        .node_identifier_string(node_identifier_string),
        .node_str_len(node_str_len), .node_has_parent(node_has_parent),
        .node_parent16(node_parent16), .node_role(node_role),
        .node_event(node_event), .busy(busy), .req_taken(req_taken),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    snf_host_model i_host (.clk(clk), .reset(reset), .stall(stall),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    always #4 clk = ~clk;

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic put(logic [63:0] v, int n);
        for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[i*8 +: 8]);
    endtask : put

    task automatic run_frame(logic node);
        int k;
        i_host.rx_q.delete();
        node_req = node;
        if (!node) sens_req = 1'b1;
        for (k = 0; k < 40 && req_taken !== 1'b1; k++) tick(1);
        sens_req = 1'b0;
        node_req = 1'b0;
        check("req_taken", 16'(req_taken), 16'h0001);
        tick(1);
        check("taken pulse", 16'(req_taken), 16'h0000);
        check("busy", 16'(busy), 16'h0001);
        for (k = 0; k < 900 && busy !== 1'b0; k++) tick(1);
        check("busy end", 16'(busy), 16'h0000);
        tick(2);
    endtask : run_frame

    // wrap expected data in delimiter, length and checksum, then compare
    task automatic check_frame(string what);
        logic [7:0]  sum;
        logic [15:0] len;
        logic [7:0]  full[$];
        sum = 8'h00;
        foreach (exp_q[i]) sum += exp_q[i];
        len = 16'(exp_q.size());
        full = {8'h7E, len[15:8], len[7:0]};
        full = {full, exp_q, 8'hFF - sum};
        check(what, 16'(i_host.rx_q.size()), 16'(full.size()));
        foreach (full[i])
            if (i < i_host.rx_q.size())
                check(what, {8'h00, i_host.rx_q[i]}, {8'h00, full[i]});
    endtask : check_frame

    task automatic refused();
        int seen;
        seen = 0;
        api_output_option = 8'h01;
        sens_req = 1'b1;
        node_req = 1'b1;
        repeat (12) begin
            tick(1);
            if (tx_valid !== 1'b0 || req_taken !== 1'b0) seen++;
        end
        sens_req = 1'b0;
        node_req = 1'b0;
        api_output_option = 8'h00;
        tick(1);
        check("refused starts", 16'(seen), 16'h0000);
    endtask : refused

    task automatic sensor_frame(logic an, logic tp, logic wet,
                                logic [2:0] opt);
        logic [15:0] t;
        int          c;
        {sens_aps_enc, sens_bcast, sens_acked} = opt;
        sens_analog_found = an;
        sens_temp_found = tp;
        water_detect_pin = ~wet;
        tick(4);
        exp_q.delete();
        put(64'h94, 1);
        put(sens_src_addr64, 8);
        put(64'(sens_src_addr16), 2);
        put(64'({opt[2], 3'h0, opt[1:0]}), 1);
        put(64'({wet, wet, 3'h0, tp, an}), 1);
        put(an ? sens_analog : 64'hFFFF_FFFF_FFFF_FFFF, 8);
        put(64'(tp ? sens_temp : 16'hFFFF), 2);
        run_frame(1'b0);
        check_frame("sensor frame");
        // host conversion of the received word, in eighths of a degree
        if (tp && i_host.rx_q.size() > 25) begin
            t = {i_host.rx_q[24], i_host.rx_q[25]};
            c = int'(i_host.temp_c(t) * 8.0);
            check("temp x8", 16'(c), 16'h00B5);
        end
    endtask : sensor_frame

    task automatic node_frame(int n, logic kn, logic hp, logic [1:0] role,
                              logic both);
        node_str_len = 5'(n);
        node_remote16_known = kn;
        node_has_parent = hp;
        node_role = role;
        node_event = role + 2'h1;
        node_acked = (role != 2'h1);
        node_bcast = (role == 2'h1);
        sens_req = both;
        exp_q.delete();
        put(64'h95, 1);
        put(node_src_addr64, 8);
        put(64'(node_src_addr16), 2);
        put(64'({node_bcast, node_acked}), 1);
        put(64'(kn ? node_remote16 : 16'hFFFE), 2);
        put(node_remote64, 8);
        for (int i = 0; i < n; i++)
            put(64'(node_identifier_string[159-8*i -: 8]), 1);
        put(64'h00, 1);
        put(64'(hp ? node_parent16 : 16'hFFFE), 2);
        put(64'(role), 1);
        put(64'(node_event), 1);
        put(64'(PROF), 2);
        run_frame(1'b1);
        check_frame("node frame");
    endtask : node_frame

    task automatic close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial begin
        reset = 1'b1;
        {sens_req, node_req, stall, api_output_option, sens_acked,
         sens_bcast, sens_aps_enc, sens_analog_found, sens_temp_found,
         node_acked, node_bcast, node_remote16_known, node_has_parent,
         node_str_len, node_role, node_event} = '0;
        water_detect_pin = 1'b1;
        sens_src_addr64 = 64'h0123_4567_89AB_CDEF;
        sens_src_addr16 = 16'h3C5A;
        sens_analog = 64'h0002_00CE_00EA_0052;
        sens_temp = 16'h016A;
        node_src_addr64 = 64'hFEDC_BA98_7654_3210;
        node_src_addr16 = 16'h7D84;
        node_remote16 = 16'h1234;
        node_remote64 = 64'h1122_3344_5566_7788;
        node_parent16 = 16'h4321;
        for (int i = 0; i < 20; i++)
            node_identifier_string[159-8*i -: 8] = 8'h41 + 8'(i);
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        tick(1);
        refused();
        sensor_frame(1'b1, 1'b1, 1'b1, 3'b101);
        stall = 1'b1;
        sensor_frame(1'b0, 1'b0, 1'b0, 3'b010);
        node_frame(0, 1'b0, 1'b0, 2'h0, 1'b1);
        stall = 1'b0;
        sensor_frame(1'b1, 1'b0, 1'b0, 3'b001);
        node_frame(1, 1'b1, 1'b1, 2'h1, 1'b0);
        node_frame(20, 1'b1, 1'b0, 2'h2, 1'b0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule : testbench
